/* File: pkg/tpw_pkg.sv */
// Constants, field layouts, reset values and mode codes of the timer pair with watchdog.
// Assumes one core clock domain; CPU instruction strobes arrive as one-cycle pulses on that clock.
// Overview of operation
// - Watchdog counter decrements once per machine cycle (instruction clock tick).
// - Each watchdog underflow sets the first watchdog flag.
// - Restart instruction clears the first watchdog flag and skips the next instruction.
// - Underflow with first flag already set sets second flag and fires watchdog reset.
// - Watchdog reset turns on the reset pin pull-down, resetting the whole system.
// - Watchdog runs after reset; disable directly followed by restart stops it.
// - Return from RAM back-up re-enables the watchdog every time.
// - Counting starts on the first count-source edge after the timer starts.
// - Count pin source counts synchronised falling edges of the pin.
// - Timer one may start on an external interrupt edge, then flag next underflow.
// - Count pin can output underflow square wave while timer one still interrupts.
// - Timer two source codes pick timer one underflow, prescaler, count pin, system clock.
// - Output select bit picks timer one or timer two underflow divided by two.
// - Timer one auto-stop acts only when start synchronisation is selected.
package tpw_pkg;

  // Timer control one fields
  localparam int CTL1_START_SYNC = 0;
  localparam int CTL1_T1_RUN = 1;
  localparam int CTL1_PRE_RATIO = 2;
  localparam int CTL1_PRE_RUN = 3;
  // Timer control two fields
  localparam int CTL2_SRC_LO = 0;
  localparam int CTL2_SRC_HI = 1;
  localparam int CTL2_AUTO_STOP = 2;
  localparam int CTL2_T2_RUN = 3;
  // Count pin control fields
  localparam int CTLP_PIN_OUT_EN = 0;
  localparam int CTLP_OUT_SEL = 1;

  localparam logic [3:0] CTL_RESET_VAL = 4'h0;
  localparam logic [7:0] TMR_RESET_VAL = 8'hFF;
  localparam int TMR_WIDTH = 8;

  // Watchdog counter
  localparam int WDOG_WIDTH = 16;
  localparam logic [15:0] WDOG_RELOAD = 16'hFFFF;

  // Prescaler ratios in machine cycles
  localparam logic [3:0] PRE_LAST_FAST = 4'h3;
  localparam logic [3:0] PRE_LAST_SLOW = 4'hF;

  // System clocks per machine cycle (high-speed mode)
  localparam int MC_DIV_DEFAULT = 3;

  // Timer two count source codes
  typedef enum logic [1:0] {
    T2_SRC_T1_UF = 2'b00,
    T2_SRC_PRESCALE = 2'b01,
    T2_SRC_PIN = 2'b10,
    T2_SRC_SYSCLK = 2'b11
  } tpw_t2src_t;

  // Watchdog states, one-hot
  typedef enum logic [3:0] {
    WD_OFF = 4'b0001,
    WD_RUN = 4'b0010,
    WD_WARN = 4'b0100,
    WD_FIRE = 4'b1000
  } tpw_wdstate_t;

endpackage : tpw_pkg

/* File: logic/tpw_timer.sv */
// One down-counting timer with reload and CPU write access.
// Assumes srcTick is a one-cycle pulse on core_clk marking a count-source edge (a falling edge for the count pin).
`timescale 1ns/1ps
module tpw_timer
  import tpw_pkg::*;
#(
  parameter int WIDTH = TMR_WIDTH
) (
  input wire logic core_clk, // System clock
  input wire logic rst, // Async reset, high
  input wire logic runEn, // Timer operating
  input wire logic srcTick, // Count source edge pulse
  input wire logic wrEn, // CPU count write strobe
  input wire logic [WIDTH-1:0] wrData, // CPU count write data
  input wire logic [WIDTH-1:0] reloadVal, // Reload register value
  output logic [WIDTH-1:0] count, // Current count
  output logic underflow // One-cycle underflow pulse
);

  initial begin
    if (WIDTH < 2 || WIDTH > 16) $error("tpw_timer: WIDTH out of range");
  end

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  logic uf_r;
  logic uf_nxt;

  // Next count: a stopped timer simply holds, so no first-tick correction is needed
  always_comb begin
    count_nxt = count_r;
    uf_nxt = 1'b0;
    if (wrEn) begin
      count_nxt = wrData;
    end else if (runEn && srcTick) begin
      if (count_r == '0) begin
        count_nxt = reloadVal;
        uf_nxt = 1'b1;
      end else begin
        count_nxt = count_r - 1'b1;
      end
    end
  end

  // Count registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count_r <= WIDTH'(TMR_RESET_VAL);
      uf_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      uf_r <= uf_nxt;
    end
  end

  assign count = count_r;
  assign underflow = uf_r;

endmodule : tpw_timer

/* File: logic/tpw_timer_pair.sv */
// Timer pair with prescaler, count pin and watchdog, driven by CPU instruction strobes.
// Assumes strobes are one-cycle pulses on core_clk; count pin and interrupt pin are asynchronous.
`timescale 1ns/1ps
module tpw_timer_pair
  import tpw_pkg::*;
#(
  parameter int MC_DIV = MC_DIV_DEFAULT
) (
  input wire logic core_clk, // System clock, 40 MHz
  input wire logic rst, // Async reset, high
  input wire logic instrDone, // Any instruction completed
  input wire logic wdogRestartOp, // Watchdog restart instruction
  input wire logic wdogDisableOp, // Watchdog disable instruction
  input wire logic ramBackupReturn, // Return from RAM back-up
  input wire logic ctlOneWr, // Write timer control one
  input wire logic ctlTwoWr, // Write timer control two
  input wire logic ctlPinWr, // Write count pin control
  input wire logic [3:0] ctlData, // Control write data
  input wire logic reloadOneWr, // Write timer one reload
  input wire logic reloadTwoWr, // Write timer two reload
  input wire logic writeTimerOneOp, // Write timer one count
  input wire logic writeTimerTwoOp, // Write timer two count
  input wire logic [7:0] accPair, // Accumulator pair data
  input wire logic tOneFlagClr, // Clear timer one request
  input wire logic tTwoFlagClr, // Clear timer two request
  input wire logic countPinIn, // Count pin level, async
  input wire logic extIntIn, // External interrupt pin, async
  output logic [3:0] timerCtrlOne, // Control one readback
  output logic [3:0] timerCtrlTwo, // Control two readback
  output logic [3:0] timerCtrlPin, // Count pin control readback
  output logic [7:0] timerOneCount, // Timer one count
  output logic [7:0] timerTwoCount, // Timer two count
  output logic tOneFlag, // Timer one request flag
  output logic tTwoFlag, // Timer two request flag
  output logic countPinOut, // Count pin output level
  output logic countPinOe, // Count pin output enable
  output logic skipNext, // Skip next instruction pulse
  output logic wdogFirstFlag, // First watchdog flag
  output logic wdogSecondFlag, // Second watchdog flag
  output logic wdogEnableFlag, // Watchdog enable flag
  output logic resetPinOut, // Reset pin pull-down level
  output logic resetPinOe // Reset pin pull-down on
);

  initial begin
    if (MC_DIV < 1 || MC_DIV > 255) $error("tpw_timer_pair: MC_DIV out of range");
  end

  // Synchronisers: first stage read only by the second
  logic [1:0] pinSync_r;
  logic [1:0] intSync_r;
  logic pinLast_r;
  logic intLast_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pinSync_r <= 2'b11;
      intSync_r <= 2'b00;
      pinLast_r <= 1'b1;
      intLast_r <= 1'b0;
    end else begin
      pinSync_r <= {pinSync_r[0], countPinIn};
      intSync_r <= {intSync_r[0], extIntIn};
      pinLast_r <= pinSync_r[1];
      intLast_r <= intSync_r[1];
    end
  end
  logic pinFall;
  logic intRise;
  assign pinFall = pinLast_r && !pinSync_r[1];
  assign intRise = !intLast_r && intSync_r[1];

  // Machine cycle divider and prescaler
  logic [7:0] mcCnt_r;
  logic [7:0] mcCnt_nxt;
  logic [3:0] preCnt_r;
  logic [3:0] preCnt_nxt;
  logic mcTick;
  logic preTick;
  logic [3:0] ctl1_r;
  logic [3:0] ctl1_nxt;
  logic [3:0] ctl2_r;
  logic [3:0] ctl2_nxt;
  logic [3:0] ctlp_r;
  logic [3:0] ctlp_nxt;
  logic [3:0] preLast;

  assign mcTick = (mcCnt_r == 8'(MC_DIV - 1));
  assign preLast = ctl1_r[CTL1_PRE_RATIO] ? PRE_LAST_SLOW : PRE_LAST_FAST;
  assign preTick = ctl1_r[CTL1_PRE_RUN] && mcTick && (preCnt_r == preLast);

  // Divider next state; ratio change mid-count is undefined until prescaler is stopped
  always_comb begin
    mcCnt_nxt = mcTick ? 8'h00 : mcCnt_r + 8'h01;
    preCnt_nxt = preCnt_r;
    if (!ctl1_r[CTL1_PRE_RUN]) begin
      preCnt_nxt = 4'h0;
    end else if (mcTick) begin
      preCnt_nxt = (preCnt_r >= preLast) ? 4'h0 : preCnt_r + 4'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mcCnt_r <= 8'h00;
      preCnt_r <= 4'h0;
    end else begin
      mcCnt_r <= mcCnt_nxt;
      preCnt_r <= preCnt_nxt;
    end
  end

  // Timer one start synchronisation and auto-stop
  logic t1Started_r;
  logic t1Started_nxt;
  logic t1Run;
  logic t1Uf;
  logic t2Uf;
  assign t1Run = ctl1_r[CTL1_T1_RUN] && (!ctl1_r[CTL1_START_SYNC] || t1Started_r);

  always_comb begin
    t1Started_nxt = t1Started_r;
    if (!ctl1_r[CTL1_T1_RUN] || !ctl1_r[CTL1_START_SYNC]) begin
      t1Started_nxt = 1'b0;
    end else if (intRise) begin
      t1Started_nxt = 1'b1;
    end else if (t1Uf && ctl2_r[CTL2_AUTO_STOP]) begin
      t1Started_nxt = 1'b0;
    end
  end

  // Control registers; RAM back-up return clears control one only
  always_comb begin
    ctl1_nxt = ctlOneWr ? ctlData : ctl1_r;
    ctl2_nxt = ctlTwoWr ? ctlData : ctl2_r;
    ctlp_nxt = ctlPinWr ? ctlData : ctlp_r;
    if (ramBackupReturn) begin
      ctl1_nxt = CTL_RESET_VAL;
    end
  end

  // Reload registers
  logic [7:0] reload1_r;
  logic [7:0] reload2_r;
  logic [7:0] reload1_nxt;
  logic [7:0] reload2_nxt;
  always_comb begin
    reload1_nxt = reloadOneWr ? accPair : reload1_r;
    reload2_nxt = reloadTwoWr ? accPair : reload2_r;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctl1_r <= CTL_RESET_VAL;
      ctl2_r <= CTL_RESET_VAL;
      ctlp_r <= CTL_RESET_VAL;
      t1Started_r <= 1'b0;
      reload1_r <= TMR_RESET_VAL;
      reload2_r <= TMR_RESET_VAL;
    end else begin
      ctl1_r <= ctl1_nxt;
      ctl2_r <= ctl2_nxt;
      ctlp_r <= ctlp_nxt;
      t1Started_r <= t1Started_nxt;
      reload1_r <= reload1_nxt;
      reload2_r <= reload2_nxt;
    end
  end

  // Timer two source mux; switching sources while running is the CPU's hazard
  logic t2Tick;
  always_comb begin
    case (tpw_t2src_t'(ctl2_r[CTL2_SRC_HI:CTL2_SRC_LO]))
      T2_SRC_T1_UF: t2Tick = t1Uf;
      T2_SRC_PRESCALE: t2Tick = preTick;
      T2_SRC_PIN: t2Tick = pinFall;
      default: t2Tick = 1'b1;
    endcase
  end

  tpw_timer #(.WIDTH(TMR_WIDTH)) timerOne (
    .core_clk(core_clk),
    .rst(rst),
    .runEn(t1Run),
    .srcTick(preTick),
    .wrEn(writeTimerOneOp),
    .wrData(accPair),
    .reloadVal(reload1_r),
    .count(timerOneCount),
    .underflow(t1Uf)
  );

  tpw_timer #(.WIDTH(TMR_WIDTH)) timerTwo (
    .core_clk(core_clk),
    .rst(rst),
    .runEn(ctl2_r[CTL2_T2_RUN]),
    .srcTick(t2Tick),
    .wrEn(writeTimerTwoOp),
    .wrData(accPair),
    .reloadVal(reload2_r),
    .count(timerTwoCount),
    .underflow(t2Uf)
  );

  // Request flags and square wave; a set beats a clear in the same cycle
  logic t1F_r;
  logic t2F_r;
  logic sq_r;
  logic t1F_nxt;
  logic t2F_nxt;
  logic sq_nxt;
  always_comb begin
    t1F_nxt = t1Uf ? 1'b1 : (tOneFlagClr ? 1'b0 : t1F_r);
    t2F_nxt = t2Uf ? 1'b1 : (tTwoFlagClr ? 1'b0 : t2F_r);
    sq_nxt = sq_r ^ (ctlp_r[CTLP_OUT_SEL] ? t2Uf : t1Uf);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      t1F_r <= 1'b0;
      t2F_r <= 1'b0;
      sq_r <= 1'b0;
    end else begin
      t1F_r <= t1F_nxt;
      t2F_r <= t2F_nxt;
      sq_r <= sq_nxt;
    end
  end

  // Watchdog: disable only takes effect when the very next instruction is restart
  tpw_wdstate_t wdState_r;
  tpw_wdstate_t wdState_nxt;
  logic [15:0] wdCnt_r;
  logic [15:0] wdCnt_nxt;
  logic disArm_r;
  logic disArm_nxt;
  logic skip_r;
  logic wdUf;
  assign wdUf = (wdState_r != WD_OFF) && (wdState_r != WD_FIRE) && mcTick && (wdCnt_r == 16'h0000);

  always_comb begin
    wdState_nxt = wdState_r;
    wdCnt_nxt = wdCnt_r;
    disArm_nxt = disArm_r;
    if (wdogDisableOp) begin
      disArm_nxt = 1'b1;
    end else if (instrDone || wdogRestartOp) begin
      disArm_nxt = 1'b0;
    end
    if (mcTick && wdState_r != WD_OFF && wdState_r != WD_FIRE) begin
      wdCnt_nxt = (wdCnt_r == 16'h0000) ? WDOG_RELOAD : wdCnt_r - 16'h0001;
    end
    case (wdState_r)
      WD_OFF: begin
        if (ramBackupReturn) begin
          wdState_nxt = WD_RUN;
          wdCnt_nxt = WDOG_RELOAD;
        end
      end
      WD_RUN: begin
        if (wdUf) begin
          wdState_nxt = WD_WARN;
        end else if (wdogRestartOp && disArm_r) begin
          wdState_nxt = WD_OFF;
        end
      end
      WD_WARN: begin
        if (wdUf) begin
          wdState_nxt = WD_FIRE;
        end else if (wdogRestartOp) begin
          wdState_nxt = disArm_r ? WD_OFF : WD_RUN;
        end
      end
      WD_FIRE: wdState_nxt = WD_FIRE; // Held until the pulled-down pin resets us
      default: wdState_nxt = WD_RUN;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wdState_r <= WD_RUN;
      wdCnt_r <= WDOG_RELOAD;
      disArm_r <= 1'b0;
      skip_r <= 1'b0;
    end else begin
      wdState_r <= wdState_nxt;
      wdCnt_r <= wdCnt_nxt;
      disArm_r <= disArm_nxt;
      skip_r <= wdogRestartOp;
    end
  end

  // Outputs
  assign timerCtrlOne = ctl1_r;
  assign timerCtrlTwo = ctl2_r;
  assign timerCtrlPin = ctlp_r;
  assign tOneFlag = t1F_r;
  assign tTwoFlag = t2F_r;
  assign countPinOut = sq_r;
  assign countPinOe = ctlp_r[CTLP_PIN_OUT_EN];
  assign skipNext = skip_r;
  assign wdogFirstFlag = (wdState_r == WD_WARN) || (wdState_r == WD_FIRE);
  assign wdogSecondFlag = (wdState_r == WD_FIRE);
  assign wdogEnableFlag = (wdState_r != WD_OFF);
  assign resetPinOut = 1'b0; // Open drain: only ever pulls low
  assign resetPinOe = (wdState_r == WD_FIRE);

endmodule : tpw_timer_pair

/* File: bench/tpw_timer_pair_props.sv */
// Port checks of the timer pair.
// Assumes one clock and async high rst.
`timescale 1ns/1ps
module tpw_timer_pair_props (
  input wire logic core_clk, // Clock
  input wire logic rst, // Reset
  input wire logic wdogRestartOp, // Restart
  input wire logic wdogDisableOp, // Disable
  input wire logic ramBackupReturn, // Wake
  input wire logic writeTimerTwoOp, // Count load
  input wire logic [3:0] timerCtrlOne, // Ctl one
  input wire logic [3:0] timerCtrlTwo, // Ctl two
  input wire logic [3:0] timerCtrlPin, // Ctl pin
  input wire logic [7:0] timerTwoCount, // Count
  input wire logic countPinOe, // Pin oe
  input wire logic skipNext, // Skip
  input wire logic wdogFirstFlag, // Flag 1
  input wire logic wdogSecondFlag, // Flag 2
  input wire logic wdogEnableFlag, // Enable
  input wire logic resetPinOut, // Pull level
  input wire logic resetPinOe // Pull on
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Stop request: disable then restart on the next cycle
  sequence s_stop_cmd;
    wdogDisableOp ##1 wdogRestartOp;
  endsequence
  a_skip_follows: assert property (wdogRestartOp |=> skipNext)
    else $error("no skip after restart");
  a_skip_cause: assert property (skipNext |-> $past(wdogRestartOp))
    else $error("skip without restart");
  a_restart_clears: assert property (wdogRestartOp && !wdogSecondFlag |=> !wdogFirstFlag)
    else $error("first flag kept");
  a_stop_seq: assert property (s_stop_cmd |=> !wdogEnableFlag && skipNext)
    else $error("watchdog not stopped");
  a_wake_enables: assert property (ramBackupReturn |=> wdogEnableFlag && timerCtrlOne == 4'h0)
    else $error("wake left watchdog off");
  a_fire_pull: assert property (resetPinOe == wdogSecondFlag && !resetPinOut)
    else $error("pull-down mismatch");
  a_second_first: assert property ($rose(wdogSecondFlag) |-> $past(wdogFirstFlag))
    else $error("second flag early");
  a_pin_enable: assert property (countPinOe == timerCtrlPin[0])
    else $error("pin enable mismatch");
  a_stop_holds: assert property (!timerCtrlTwo[3] && !writeTimerTwoOp |=> $stable(timerTwoCount))
    else $error("stopped count moved");
  a_sys_step: assert property (timerCtrlTwo == 4'hB && timerTwoCount != 8'h00 && !writeTimerTwoOp
    |=> timerTwoCount == $past(timerTwoCount) - 8'h01)
    else $error("clock source miscount");
endmodule : tpw_timer_pair_props
bind tpw_timer_pair tpw_timer_pair_props u_props (.core_clk, .rst, .wdogRestartOp, .wdogDisableOp,
  .ramBackupReturn, .writeTimerTwoOp, .timerCtrlOne, .timerCtrlTwo, .timerCtrlPin, .timerTwoCount,
  .countPinOe, .skipNext, .wdogFirstFlag, .wdogSecondFlag, .wdogEnableFlag, .resetPinOut, .resetPinOe);

/* File: bench/tpw_cpu_model.sv */
// CPU core model issuing instruction strobes.
// Assumes the bench calls exec, then idle.
`timescale 1ns/1ps
module tpw_cpu_model (
  input wire logic core_clk, // Clock
  output logic instrDone, // Any op
  output logic wdogRestartOp, // Op 0
  output logic wdogDisableOp, // Op 1
  output logic ramBackupReturn, // Op 2
  output logic ctlOneWr, // Op 3
  output logic ctlTwoWr, // Op 4
  output logic ctlPinWr, // Op 5
  output logic reloadOneWr, // Op 6
  output logic reloadTwoWr, // Op 7
  output logic writeTimerOneOp, // Op 8
  output logic writeTimerTwoOp, // Op 9
  output logic tOneFlagClr, // Op 10
  output logic tTwoFlagClr, // Op 11
  output logic [3:0] ctlData, // Ctl data
  output logic [7:0] accPair // Acc data
);
  logic [12:0] opSel;
  // One-hot strobes; bit 12 is a plain op
  assign {tTwoFlagClr, tOneFlagClr, writeTimerTwoOp, writeTimerOneOp, reloadTwoWr, reloadOneWr,
    ctlPinWr, ctlTwoWr, ctlOneWr, ramBackupReturn, wdogDisableOp, wdogRestartOp} = opSel[11:0];
  assign instrDone = |opSel;
  initial begin
    opSel = 13'h0000;
    ctlData = 4'h0;
    accPair = 8'h00;
  end
  // Calls run back to back; units are changed only while stopped
  task automatic exec(input int idx, input logic [7:0] d);
    @(negedge core_clk);
    opSel = 13'h0001 << idx;
    ctlData = d[3:0];
    accPair = d;
  endtask : exec
  // Released data shows the inverse, never a stale copy
  task automatic idle();
    @(negedge core_clk);
    opSel = 13'h0000;
    ctlData = ~ctlData;
    accPair = ~accPair;
  endtask : idle
endmodule : tpw_cpu_model

/* File: bench/testbench.sv */
// Self-checking bench of the timer pair.
// Assumes MC_DIV of 1: one machine cycle per clock.
`timescale 1ns/1ps
module testbench;
  import tpw_pkg::*;
  localparam int OP_RS = 0, OP_DIS = 1, OP_RAM = 2, OP_C1 = 3, OP_C2 = 4, OP_CP = 5, OP_L1 = 6;
  localparam int OP_L2 = 7, OP_T1 = 8, OP_T2 = 9, OP_K1 = 10, OP_K2 = 11, OP_NOP = 12;
  typedef struct {logic [1:0] src; int drop;} tpw_row_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic countPinIn = 1'b1;
  logic extIntIn = 1'b0;
  logic instrDone, wdogRestartOp, wdogDisableOp, ramBackupReturn, ctlOneWr, ctlTwoWr, ctlPinWr;
  logic reloadOneWr, reloadTwoWr, writeTimerOneOp, writeTimerTwoOp, tOneFlagClr, tTwoFlagClr;
  logic [3:0] ctlData, timerCtrlOne, timerCtrlTwo, timerCtrlPin;
  logic [7:0] accPair, timerOneCount, timerTwoCount;
  logic tOneFlag, tTwoFlag, countPinOut, countPinOe, skipNext;
  logic wdogFirstFlag, wdogSecondFlag, wdogEnableFlag, resetPinOut, resetPinOe;
  int nFail = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  // Source code and count drop over 64 clocks
  tpw_row_t rows [3] = '{'{2'b00, 8}, '{2'b01, 16}, '{2'b11, 64}};
  tpw_cpu_model cpu (.core_clk, .instrDone, .wdogRestartOp, .wdogDisableOp, .ramBackupReturn,
    .ctlOneWr, .ctlTwoWr, .ctlPinWr, .reloadOneWr, .reloadTwoWr, .writeTimerOneOp, .writeTimerTwoOp,
    .tOneFlagClr, .tTwoFlagClr, .ctlData, .accPair);
  tpw_timer_pair #(.MC_DIV(1)) dut (.core_clk, .rst, .instrDone, .wdogRestartOp, .wdogDisableOp,
    .ramBackupReturn, .ctlOneWr, .ctlTwoWr, .ctlPinWr, .ctlData, .reloadOneWr, .reloadTwoWr,
    .writeTimerOneOp, .writeTimerTwoOp, .accPair, .tOneFlagClr, .tTwoFlagClr, .countPinIn, .extIntIn,
    .timerCtrlOne, .timerCtrlTwo, .timerCtrlPin, .timerOneCount, .timerTwoCount, .tOneFlag, .tTwoFlag,
    .countPinOut, .countPinOe, .skipNext, .wdogFirstFlag, .wdogSecondFlag, .wdogEnableFlag,
    .resetPinOut, .resetPinOe);
  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;
  task automatic close_out();
    $display("checks %0d failures %0d", checked, nFail);
    if (nFail == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  // The run needs about 66000 clocks
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 80000) begin
      nFail++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      nFail++;
    end
  endtask : chk
  task automatic op(input int i, input logic [7:0] d);
    cpu.exec(i, d);
    cpu.idle();
  endtask : op
  // Clocks between two toggles of the count pin
  task automatic gap(output int k);
    logic v;
    for (int j = 0; j < 2; j++) begin
      v = countPinOut;
      k = 0;
      while (countPinOut === v && k < 200) begin
        @(negedge core_clk);
        k++;
      end
    end
  endtask : gap
  // Main sequence
  initial begin
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    chk({timerCtrlOne, timerCtrlTwo, timerCtrlPin, timerOneCount, timerTwoCount}, 28'h000FFFF);
    chk({wdogEnableFlag, wdogFirstFlag, wdogSecondFlag, resetPinOe, resetPinOut}, 5'h10);
    cpu.exec(OP_DIS, 8'h00);
    cpu.exec(OP_RS, 8'h00);
    cpu.idle();
    chk({skipNext, wdogEnableFlag}, 2'h2);
    $display("test reset done");
    // Timer one underflows every 8 clocks
    op(OP_L1, 8'h01);
    op(OP_T1, 8'h01);
    op(OP_C1, 8'h0A);
    foreach (rows[i]) begin
      op(OP_C2, {6'h00, rows[i].src});
      op(OP_T2, 8'hF0);
      op(OP_C2, {6'h02, rows[i].src});
      repeat (62) @(negedge core_clk);
      op(OP_C2, {6'h00, rows[i].src});
      n = 240 - int'(timerTwoCount);
      chk(n >= rows[i].drop - 1 && n <= rows[i].drop + 1, 1'b1);
    end
    $display("test sources done");
    op(OP_CP, 8'h01);
    gap(n);
    chk(n, 8);
    op(OP_C1, 8'h02);
    op(OP_C1, 8'h06);
    op(OP_C1, 8'h0E);
    gap(n);
    chk(n, 32);
    chk({countPinOe, tOneFlag}, 2'h3);
    op(OP_T2, 8'h03);
    op(OP_L2, 8'h03);
    op(OP_C2, 8'h0B);
    op(OP_CP, 8'h03);
    gap(n);
    chk(n, 4);
    chk({tTwoFlag, timerCtrlTwo, timerCtrlPin}, 9'h1B3);
    op(OP_C2, 8'h02);
    // Timer two is stopped, so no underflow can win over the clear
    op(OP_K2, 8'h00);
    chk(tTwoFlag, 1'b0);
    op(OP_T2, 8'h10);
    op(OP_C2, 8'h0A);
    // Six clocks per level, above the minimum width
    repeat (3) begin
      countPinIn = 1'b0;
      repeat (6) @(negedge core_clk);
      countPinIn = 1'b1;
      repeat (6) @(negedge core_clk);
    end
    op(OP_C2, 8'h02);
    chk(timerTwoCount, 8'h0D);
    op(OP_C1, 8'h00);
    op(OP_K1, 8'h00);
    op(OP_T1, 8'h05);
    op(OP_C1, 8'h0B);
    repeat (20) @(negedge core_clk);
    chk({timerOneCount, tOneFlag}, 9'h00A);
    extIntIn = 1'b1;
    repeat (40) @(negedge core_clk);
    chk(tOneFlag, 1'b1);
    // Auto-stop: the next underflow parks timer one at its reload value
    op(OP_C2, 8'h06);
    repeat (20) @(negedge core_clk);
    chk(timerOneCount, 8'h01);
    // A free-running timer would have moved within one prescaler period
    repeat (4) @(negedge core_clk);
    chk(timerOneCount, 8'h01);
    $display("test timers done");
    op(OP_RAM, 8'h00);
    chk({wdogEnableFlag, timerCtrlOne}, 5'h10);
    n = 0;
    while (wdogFirstFlag !== 1'b1 && n < 70000) begin
      @(negedge core_clk);
      n++;
    end
    chk(n >= 65535 && n <= 65537, 1'b1);
    op(OP_RS, 8'h00);
    chk(wdogFirstFlag, 1'b0);
    cpu.exec(OP_DIS, 8'h00);
    cpu.exec(OP_NOP, 8'h00);
    cpu.exec(OP_RS, 8'h00);
    cpu.idle();
    chk({wdogEnableFlag, wdogSecondFlag}, 2'h2);
    $display("test watchdog done");
    close_out();
  end
endmodule : testbench
